// *** hdl/smt_pkg.sv ***
// constants, types and helpers shared by the measurement timer files
package smt_pkg;

	localparam int COUNT_WIDTH = 24;
	localparam int ADDR_WIDTH = 5;
	localparam int DATA_WIDTH = 8;
	localparam int SEL_WIDTH = 5;
	localparam int SOURCE_COUNT = 25;

	// register offsets
	localparam logic [4:0] ADDR_SOURCE_SELECT = 5'h00;
	localparam logic [4:0] ADDR_COUNTER_LOW = 5'h01;
	localparam logic [4:0] ADDR_COUNTER_HIGH = 5'h02;
	localparam logic [4:0] ADDR_COUNTER_UPPER = 5'h03;
	localparam logic [4:0] ADDR_PERIOD_CAP_LOW = 5'h04;
	localparam logic [4:0] ADDR_PERIOD_CAP_HIGH = 5'h05;
	localparam logic [4:0] ADDR_PERIOD_CAP_UPPER = 5'h06;
	localparam logic [4:0] ADDR_WIDTH_CAP_LOW = 5'h07;
	localparam logic [4:0] ADDR_WIDTH_CAP_HIGH = 5'h08;
	localparam logic [4:0] ADDR_WIDTH_CAP_UPPER = 5'h09;
	localparam logic [4:0] ADDR_PERIOD_MATCH_LOW = 5'h0A;
	localparam logic [4:0] ADDR_PERIOD_MATCH_HIGH = 5'h0B;
	localparam logic [4:0] ADDR_PERIOD_MATCH_UPPER = 5'h0C;
	localparam logic [4:0] ADDR_CONTROL = 5'h0D;
	localparam logic [4:0] ADDR_STATUS = 5'h0E;

	// source select codes
	localparam logic [4:0] SEL_PIN = 5'h00;
	localparam logic [4:0] SEL_MATCH_ONE = 5'h08;
	localparam logic [4:0] SEL_MATCH_TWO = 5'h09;
	localparam logic [4:0] SEL_LAST = 5'h18;

	// field positions
	localparam int CTRL_GO_BIT = 0;
	localparam int CTRL_HALT_BIT = 1;
	localparam int STAT_MATCH_BIT = 0;
	localparam int STAT_PERIOD_BIT = 1;
	localparam int STAT_WIDTH_BIT = 2;
	localparam int STAT_RUN_BIT = 3;
	localparam int STAT_LEVEL_BIT = 4;

	// reset values
	localparam logic [4:0] SOURCE_SELECT_RESET = 5'h00;
	localparam logic [23:0] COUNTER_RESET = 24'h000000;
	localparam logic [23:0] PERIOD_MATCH_RESET = 24'hFFFFFF;
	localparam logic [23:0] CAPTURE_RESET = 24'h000000;
	localparam logic [23:0] COUNTER_ONE = 24'h000001;

	typedef enum logic [2:0] {
		ACQ_IDLE = 3'b001,
		ACQ_ARMED = 3'b010,
		ACQ_MEASURE = 3'b100
	} acq_state_type;

	// byte lane idx of a 24-bit value
	function automatic logic [7:0] byte_of(input logic [23:0] value, input logic [1:0] idx);
		logic [7:0] result;
		result = 8'h00;
		case (idx)
			2'h0: result = value[7:0];
			2'h1: result = value[15:8];
			2'h2: result = value[23:16];
			default: result = 8'h00;
		endcase
		return result;
	endfunction : byte_of

	// replace byte lane idx of a 24-bit value
	function automatic logic [23:0] with_byte(input logic [23:0] value, input logic [1:0] idx,
		input logic [7:0] data);
		logic [23:0] result;
		result = value;
		case (idx)
			2'h0: result[7:0] = data;
			2'h1: result[15:8] = data;
			2'h2: result[23:16] = data;
			default: result = value;
		endcase
		return result;
	endfunction : with_byte

endpackage : smt_pkg

// *** hdl/source_select_if.sv ***
// carries the source code to the selector and the picked level back
`timescale 1ns/1ps
`default_nettype none
interface source_select_if;
	logic [4:0] code;
	logic selected;
	modport selector (input code, output selected);
	modport timer (output code, input selected);
endinterface : source_select_if
`default_nettype wire

// *** hdl/signal_source_mux.sv ***
// synchronises the candidate sources and picks the measured signal
`timescale 1ns/1ps
`default_nettype none
module signal_source_mux #(
	parameter logic INSTANCE_ID = 1'b0
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// candidate sources, bit index equals select code
	input wire logic [smt_pkg::SOURCE_COUNT-1:0] raw_sources,
	// towards the timer
	source_select_if.selector sel
);

	logic [smt_pkg::SOURCE_COUNT-1:0] sync_first;
	logic [smt_pkg::SOURCE_COUNT-1:0] sync_second;
	logic picked;
	logic next_picked;
	logic [4:0] own_match_code;

	assign own_match_code = INSTANCE_ID ? smt_pkg::SEL_MATCH_TWO : smt_pkg::SEL_MATCH_ONE;

	////////////////////////////////////////////////////////////////////////////////
	// selection
	always_comb begin
		next_picked = 1'b0;
		if (sel.code <= smt_pkg::SEL_LAST && sel.code != own_match_code) begin // see [R1] [R2] [R3]
			next_picked = sync_second[sel.code];
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sync_first <= '0;
			sync_second <= '0;
			picked <= 1'b0;
		end else begin
			sync_first <= raw_sources;
			sync_second <= sync_first;
			picked <= next_picked;
		end
	end

	assign sel.selected = picked;

endmodule : signal_source_mux
`default_nettype wire

// *** hdl/signal_measurement_timer.sv ***
// 24-bit signal measurement timer with byte-wide register port
//
// Behaviour
// [R1] 5-bit source code: 0 pin, 1 timer0, 2-7 timers, 8-9 match outputs.
// [R2] Codes 10-24 pick compare, pwm, oscillator, comparator, zero-cross, logic cells.
// [R3] Match code naming this instance itself is reserved and picks nothing.
// [R4] Select register bits 7-5 read zero; bits 4-0 reset to zero.
// [R5] Counter appears as low, high and upper byte registers.
// [R6] Counter bytes read and write by software; all reset to zero.
// [R7] Captured period is three read-only bytes, content undefined after reset.
// [R8] Captured pulse width is three read-only bytes, undefined after reset.
// [R9] Period match low and high bytes read/write; reset to all ones.
// [R10] Period match upper byte behaves like the lower two bytes.
// [R11] On match counter holds if halt set, else restarts; match pulses out.
// [R12] Captures load only from the counter; software writes to them are ignored.
`timescale 1ns/1ps
`default_nettype none
module signal_measurement_timer #(
	parameter logic INSTANCE_ID = 1'b0
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// register port
	input wire logic [smt_pkg::ADDR_WIDTH-1:0] reg_addr,
	input wire logic [smt_pkg::DATA_WIDTH-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [smt_pkg::DATA_WIDTH-1:0] reg_rdata,
	// measured signal candidates
	input wire logic pin_routed_signal_input,
	input wire logic [smt_pkg::SOURCE_COUNT-1:1] peripheral_sources,
	// match event
	output logic timer_match_output
);

	////////////////////////////////////////////////////////////////////////////////
	// state
	logic [4:0] source_select;
	logic [23:0] measure_counter;
	logic [23:0] period_match_value;
	logic [23:0] captured_period;
	logic [23:0] captured_pulse_width;
	logic go;
	logic halt_on_match;
	logic match_seen;
	logic period_new;
	logic width_new;
	logic level_prev;
	logic match_pulse;
	logic [7:0] rdata;
	smt_pkg::acq_state_type acq_state;

	logic [4:0] next_source_select;
	logic [23:0] next_measure_counter;
	logic [23:0] next_period_match_value;
	logic [23:0] next_captured_period;
	logic [23:0] next_captured_pulse_width;
	logic next_go;
	logic next_halt_on_match;
	logic next_match_seen;
	logic next_period_new;
	logic next_width_new;
	logic next_match_pulse;
	logic [7:0] next_rdata;
	smt_pkg::acq_state_type next_acq_state;

	logic level;
	logic rise;
	logic fall;
	logic counting;
	logic at_match;
	logic ev_match;
	logic ev_period;
	logic ev_width;
	logic [7:0] status_byte;

	source_select_if sel_bus ();

	////////////////////////////////////////////////////////////////////////////////
	// source selection
	assign sel_bus.code = source_select;

	signal_source_mux #(
		.INSTANCE_ID(INSTANCE_ID)
	) u_source_mux (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.raw_sources({peripheral_sources, pin_routed_signal_input}),
		.sel(sel_bus.selector)
	);

	assign level = sel_bus.selected;
	assign rise = level & ~level_prev;
	assign fall = ~level & level_prev;
	assign counting = go && acq_state != smt_pkg::ACQ_IDLE;
	assign at_match = measure_counter == period_match_value;

	always_comb begin
		status_byte = 8'h00;
		status_byte[smt_pkg::STAT_MATCH_BIT] = match_seen;
		status_byte[smt_pkg::STAT_PERIOD_BIT] = period_new;
		status_byte[smt_pkg::STAT_WIDTH_BIT] = width_new;
		status_byte[smt_pkg::STAT_RUN_BIT] = counting;
		status_byte[smt_pkg::STAT_LEVEL_BIT] = level;
	end

	////////////////////////////////////////////////////////////////////////////////
	// acquisition, counting and register access
	always_comb begin
		next_source_select = source_select;
		next_measure_counter = measure_counter;
		next_period_match_value = period_match_value;
		next_captured_period = captured_period;
		next_captured_pulse_width = captured_pulse_width;
		next_go = go;
		next_halt_on_match = halt_on_match;
		next_acq_state = acq_state;
		ev_match = 1'b0;
		ev_period = 1'b0;
		ev_width = 1'b0;

		// counting and period match
		if (counting) begin
			if (at_match) begin
				ev_match = 1'b1; // see [R11]
				next_measure_counter = halt_on_match ? measure_counter : smt_pkg::COUNTER_RESET; // see [R11]
			end else begin
				next_measure_counter = measure_counter + smt_pkg::COUNTER_ONE;
			end
		end

		// acquisition sequence
		case (acq_state)
			smt_pkg::ACQ_IDLE: begin
				if (go) begin
					next_acq_state = smt_pkg::ACQ_ARMED;
				end
			end
			smt_pkg::ACQ_ARMED: begin
				if (!go) begin
					next_acq_state = smt_pkg::ACQ_IDLE;
				end else if (rise) begin
					next_measure_counter = smt_pkg::COUNTER_RESET;
					next_acq_state = smt_pkg::ACQ_MEASURE;
				end
			end
			smt_pkg::ACQ_MEASURE: begin
				if (!go) begin
					next_acq_state = smt_pkg::ACQ_IDLE;
				end else if (rise) begin
					next_captured_period = measure_counter; // see [R7] [R12]
					next_measure_counter = smt_pkg::COUNTER_RESET;
					ev_period = 1'b1;
				end else if (fall) begin
					next_captured_pulse_width = measure_counter; // see [R8] [R12]
					ev_width = 1'b1;
				end
			end
			default: begin
				next_acq_state = smt_pkg::ACQ_IDLE;
			end
		endcase

		// software writes win over counting in the same cycle
		if (reg_write) begin
			case (reg_addr)
				smt_pkg::ADDR_SOURCE_SELECT: begin
					next_source_select = reg_wdata[4:0]; // see [R4]
				end
				smt_pkg::ADDR_COUNTER_LOW: begin
					next_measure_counter = smt_pkg::with_byte(measure_counter, 2'h0, reg_wdata); // see [R5] [R6]
				end
				smt_pkg::ADDR_COUNTER_HIGH: begin
					next_measure_counter = smt_pkg::with_byte(measure_counter, 2'h1, reg_wdata); // see [R5] [R6]
				end
				smt_pkg::ADDR_COUNTER_UPPER: begin
					next_measure_counter = smt_pkg::with_byte(measure_counter, 2'h2, reg_wdata); // see [R5] [R6]
				end
				smt_pkg::ADDR_PERIOD_MATCH_LOW: begin
					next_period_match_value = smt_pkg::with_byte(period_match_value, 2'h0, reg_wdata); // see [R9]
				end
				smt_pkg::ADDR_PERIOD_MATCH_HIGH: begin
					next_period_match_value = smt_pkg::with_byte(period_match_value, 2'h1, reg_wdata); // see [R9]
				end
				smt_pkg::ADDR_PERIOD_MATCH_UPPER: begin
					next_period_match_value = smt_pkg::with_byte(period_match_value, 2'h2, reg_wdata); // see [R10]
				end
				smt_pkg::ADDR_CONTROL: begin
					next_go = reg_wdata[smt_pkg::CTRL_GO_BIT];
					next_halt_on_match = reg_wdata[smt_pkg::CTRL_HALT_BIT];
				end
				default: begin
					// captures and unmapped: no stored effect; status writes clear flags below
					next_go = go; // see [R12]
				end
			endcase
		end
	end

	// sticky flags: write one clears, a new event wins
	always_comb begin
		next_match_seen = match_seen;
		next_period_new = period_new;
		next_width_new = width_new;
		if (reg_write && reg_addr == smt_pkg::ADDR_STATUS) begin
			next_match_seen = match_seen & ~reg_wdata[smt_pkg::STAT_MATCH_BIT];
			next_period_new = period_new & ~reg_wdata[smt_pkg::STAT_PERIOD_BIT];
			next_width_new = width_new & ~reg_wdata[smt_pkg::STAT_WIDTH_BIT];
		end
		next_match_seen = next_match_seen | ev_match;
		next_period_new = next_period_new | ev_period;
		next_width_new = next_width_new | ev_width;
		next_match_pulse = ev_match; // see [R11]
	end

	// read data, valid only in the cycle after the strobe
	always_comb begin
		next_rdata = 8'h00;
		if (reg_read) begin
			case (reg_addr)
				smt_pkg::ADDR_SOURCE_SELECT: next_rdata = {3'h0, source_select}; // see [R4]
				smt_pkg::ADDR_COUNTER_LOW: next_rdata = smt_pkg::byte_of(measure_counter, 2'h0); // see [R5]
				smt_pkg::ADDR_COUNTER_HIGH: next_rdata = smt_pkg::byte_of(measure_counter, 2'h1); // see [R5]
				smt_pkg::ADDR_COUNTER_UPPER: next_rdata = smt_pkg::byte_of(measure_counter, 2'h2); // see [R5]
				smt_pkg::ADDR_PERIOD_CAP_LOW: next_rdata = smt_pkg::byte_of(captured_period, 2'h0); // see [R7]
				smt_pkg::ADDR_PERIOD_CAP_HIGH: next_rdata = smt_pkg::byte_of(captured_period, 2'h1); // see [R7]
				smt_pkg::ADDR_PERIOD_CAP_UPPER: next_rdata = smt_pkg::byte_of(captured_period, 2'h2); // see [R7]
				smt_pkg::ADDR_WIDTH_CAP_LOW: next_rdata = smt_pkg::byte_of(captured_pulse_width, 2'h0); // see [R8]
				smt_pkg::ADDR_WIDTH_CAP_HIGH: next_rdata = smt_pkg::byte_of(captured_pulse_width, 2'h1); // see [R8]
				smt_pkg::ADDR_WIDTH_CAP_UPPER: next_rdata = smt_pkg::byte_of(captured_pulse_width, 2'h2); // see [R8]
				smt_pkg::ADDR_PERIOD_MATCH_LOW: next_rdata = smt_pkg::byte_of(period_match_value, 2'h0); // see [R9]
				smt_pkg::ADDR_PERIOD_MATCH_HIGH: next_rdata = smt_pkg::byte_of(period_match_value, 2'h1); // see [R9]
				smt_pkg::ADDR_PERIOD_MATCH_UPPER: next_rdata = smt_pkg::byte_of(period_match_value, 2'h2); // see [R10]
				smt_pkg::ADDR_CONTROL: begin
					next_rdata[smt_pkg::CTRL_GO_BIT] = go;
					next_rdata[smt_pkg::CTRL_HALT_BIT] = halt_on_match;
				end
				smt_pkg::ADDR_STATUS: next_rdata = status_byte;
				default: next_rdata = 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			source_select <= smt_pkg::SOURCE_SELECT_RESET; // see [R4]
			measure_counter <= smt_pkg::COUNTER_RESET; // see [R6]
			period_match_value <= smt_pkg::PERIOD_MATCH_RESET; // see [R9] [R10]
			captured_period <= smt_pkg::CAPTURE_RESET;
			captured_pulse_width <= smt_pkg::CAPTURE_RESET;
			go <= 1'b0;
			halt_on_match <= 1'b0;
			match_seen <= 1'b0;
			period_new <= 1'b0;
			width_new <= 1'b0;
			level_prev <= 1'b0;
			match_pulse <= 1'b0;
			rdata <= 8'h00;
			acq_state <= smt_pkg::ACQ_IDLE;
		end else begin
			source_select <= next_source_select;
			measure_counter <= next_measure_counter;
			period_match_value <= next_period_match_value;
			captured_period <= next_captured_period;
			captured_pulse_width <= next_captured_pulse_width;
			go <= next_go;
			halt_on_match <= next_halt_on_match;
			match_seen <= next_match_seen;
			period_new <= next_period_new;
			width_new <= next_width_new;
			level_prev <= level;
			match_pulse <= next_match_pulse;
			rdata <= next_rdata;
			acq_state <= next_acq_state;
		end
	end

	assign reg_rdata = rdata;
	assign timer_match_output = match_pulse;

endmodule : signal_measurement_timer
`default_nettype wire

// *** tb/signal_measurement_timer_assertions.sv ***
// property checker bound to the measurement timer ports
`timescale 1ns/1ps
`default_nettype none
module signal_measurement_timer_assertions #(
	parameter logic INSTANCE_ID = 1'b0
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// register port
	input wire logic [4:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	// measured signals and match
	input wire logic pin_routed_signal_input,
	input wire logic [24:1] peripheral_sources,
	input wire logic timer_match_output
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	AST_RDATA_QUIET: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
		else $error("read data not idle");
	AST_SELECT_TOP_ZERO: assert property (($past(reg_read) && $past(reg_addr) == 5'h00)
		|-> reg_rdata[7:5] == 3'h0) else $error("select top bits set");
	AST_SELECT_BACK: assert property ((reg_write && reg_addr == 5'h00) ##1
		(reg_read && reg_addr == 5'h00) |=> reg_rdata == ($past(reg_wdata, 2) & 8'h1F))
		else $error("select readback wrong");
	AST_MATCH_LOW_BACK: assert property ((reg_write && reg_addr == 5'h0A) ##1
		(reg_read && reg_addr == 5'h0A) |=> reg_rdata == $past(reg_wdata, 2))
		else $error("period low readback wrong");
	AST_MATCH_HIGH_BACK: assert property ((reg_write && reg_addr == 5'h0B) ##1
		(reg_read && reg_addr == 5'h0B) |=> reg_rdata == $past(reg_wdata, 2))
		else $error("period high readback wrong");
	AST_MATCH_UPPER_BACK: assert property ((reg_write && reg_addr == 5'h0C) ##1
		(reg_read && reg_addr == 5'h0C) |=> reg_rdata == $past(reg_wdata, 2))
		else $error("period upper readback wrong");
	AST_UNMAPPED_ZERO: assert property (($past(reg_read) && $past(reg_addr) > 5'h0E)
		|-> reg_rdata == 8'h00) else $error("unmapped read not zero");
	AST_MATCH_AFTER_RESET: assert property (!$past(reset_n) |-> !timer_match_output)
		else $error("match pulse right after reset");
endmodule : signal_measurement_timer_assertions
bind signal_measurement_timer signal_measurement_timer_assertions #(.INSTANCE_ID(INSTANCE_ID))
	checks (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.pin_routed_signal_input(pin_routed_signal_input),
	.peripheral_sources(peripheral_sources), .timer_match_output(timer_match_output));
`default_nettype wire

// *** tb/source_driver.sv ***
// square wave on the picked candidate line, fast toggle on all others
`timescale 1ns/1ps
`default_nettype none
module source_driver (
	// clock and control
	input wire logic core_clk,
	input wire logic run,
	input wire logic [4:0] pick,
	input wire logic [7:0] high_len,
	input wire logic [7:0] low_len,
	// candidate lines
	output logic pin_line,
	output logic [24:1] peripheral_lines
);
	logic [8:0] cnt;
	logic level;
	always_ff @(posedge core_clk) begin
		if (!run || cnt >= 9'(high_len) + 9'(low_len) - 9'h001) begin
			cnt <= 9'h000;
		end else begin
			cnt <= cnt + 9'h001;
		end
	end
	assign level = run && (cnt < 9'(high_len));
	always_comb begin
		pin_line = (pick == 5'h00) ? level : cnt[0];
		for (int i = 1; i < 25; i++) begin
			peripheral_lines[i] = (pick == 5'(i)) ? level : cnt[0];
		end
	end
endmodule : source_driver
`default_nettype wire

// *** tb/signal_measurement_timer_test.sv ***
// self-checking bench for the measurement timer
`timescale 1ns/1ps
`default_nettype none
module signal_measurement_timer_test;
`define CHECK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
	$display("unexpected at %0t got %h expected %h", $time, (g), (e)); end end
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [4:0] reg_addr = 5'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [7:0] reg_rdata;
	logic pin_line;
	logic [24:1] peripheral_lines;
	logic timer_match_output;
	logic run = 1'b0;
	logic [4:0] pick = 5'h00;
	logic [7:0] high_len = 8'h07;
	logic [7:0] low_len = 8'h03;
	int num_errors = 0;
	int checked = 0;
	always #12.5 core_clk = ~core_clk;
	signal_measurement_timer #(.INSTANCE_ID(1'b0)) dut (.core_clk(core_clk), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .pin_routed_signal_input(pin_line),
		.peripheral_sources(peripheral_lines), .timer_match_output(timer_match_output));
	source_driver model (.core_clk(core_clk), .run(run), .pick(pick), .high_len(high_len),
		.low_len(low_len), .pin_line(pin_line), .peripheral_lines(peripheral_lines));
	////////////////////////////////////////////////////////////////////////////////
	task automatic acc(input logic [4:0] a, input logic [7:0] d, input bit w, input bit r,
		output logic [7:0] q);
		q = 8'h00;
		if (w) begin
			@(posedge core_clk);
			reg_write <= 1'b1;
			reg_addr <= a;
			reg_wdata <= d;
		end
		@(posedge core_clk);
		reg_write <= 1'b0;
		reg_read <= r;
		reg_addr <= a;
		if (r) begin
			@(posedge core_clk);
			reg_read <= 1'b0;
			#1 q = reg_rdata;
		end
	endtask : acc
	task automatic rd24(input logic [4:0] a, output logic [23:0] v);
		for (int i = 0; i < 3; i++) begin
			acc(a + 5'(i), 8'h00, 1'b0, 1'b1, v[8*i +: 8]);
		end
	endtask : rd24
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : wrap_up
	task automatic wait_match(output int n);
		for (n = 0; n < 1000; n++) begin
			@(negedge core_clk);
			if (timer_match_output === 1'b1) break;
		end
		if (n == 1000) begin
			num_errors++;
			wrap_up();
		end
	endtask : wait_match
	task automatic apply_reset;
		@(posedge core_clk);
		reset_n <= 1'b0;
		run <= 1'b0;
		repeat (5) @(posedge core_clk);
		reset_n <= 1'b1;
	endtask : apply_reset
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset_values;
		logic [23:0] v;
		acc(5'h00, 8'h00, 1'b0, 1'b1, v[7:0]);
		`CHECK(v[7:0], 8'h00);
		rd24(5'h01, v);
		`CHECK(v, 24'h000000);
		rd24(5'h0A, v);
		`CHECK(v, 24'hFFFFFF);
		acc(5'h0D, 8'h00, 1'b0, 1'b1, v[7:0]);
		`CHECK(v[7:0], 8'h00);
		acc(5'h0E, 8'h00, 1'b0, 1'b1, v[7:0]);
		`CHECK(v[7:0], 8'h00);
		$display("done reset_values");
	endtask : t_reset_values
	task automatic t_rw;
		logic [7:0] q;
		logic [23:0] v;
		acc(5'h00, 8'hFF, 1'b1, 1'b1, q);
		`CHECK(q, 8'h1F);
		for (int i = 0; i < 3; i++) begin
			acc(5'h01 + 5'(i), 8'h3C + 8'(i), 1'b1, 1'b1, q);
			`CHECK(q, 8'h3C + 8'(i));
			acc(5'h0A + 5'(i), 8'hA1 + 8'(i), 1'b1, 1'b1, q);
			`CHECK(q, 8'hA1 + 8'(i));
		end
		rd24(5'h01, v);
		`CHECK(v, 24'h3E3D3C);
		acc(5'h1F, 8'h00, 1'b0, 1'b1, q);
		`CHECK(q, 8'h00);
		$display("done register_rw");
	endtask : t_rw
	task automatic t_sources;
		logic [23:0] per;
		logic [23:0] wid;
		logic [23:0] old;
		logic [7:0] q;
		for (int c = 0; c < 32; c++) begin
			rd24(5'h04, old);
			acc(5'h00, 8'(c), 1'b1, 1'b0, q);
			pick <= 5'(c);
			low_len <= 8'h03 + 8'(c % 4);
			acc(5'h0D, 8'h01, 1'b1, 1'b0, q);
			run <= 1'b1;
			repeat (60) @(posedge core_clk);
			acc(5'h0D, 8'h00, 1'b1, 1'b0, q);
			run <= 1'b0;
			rd24(5'h04, per);
			rd24(5'h07, wid);
			// code 8 is this instance's own match output
			if (c > 24 || c == 8) begin
				`CHECK(per, old);
			end else begin
				`CHECK(per - wid, 24'(3 + c % 4));
			end
		end
		$display("done source_codes");
	endtask : t_sources
	task automatic t_capture_ro;
		logic [7:0] b;
		logic [7:0] q;
		for (int i = 0; i < 6; i++) begin
			acc(5'h04 + 5'(i), 8'h00, 1'b0, 1'b1, b);
			acc(5'h04 + 5'(i), ~b, 1'b1, 1'b1, q);
			`CHECK(q, b);
		end
		$display("done capture_read_only");
	endtask : t_capture_ro
	task automatic t_match;
		logic [7:0] q;
		logic [23:0] v;
		int n;
		for (int i = 0; i < 3; i++) begin
			acc(5'h01 + 5'(i), 8'h00, 1'b1, 1'b0, q);
			acc(5'h0A + 5'(i), (i == 0) ? 8'h09 : 8'h00, 1'b1, 1'b0, q);
		end
		acc(5'h00, 8'h00, 1'b1, 1'b0, q);
		pick <= 5'h00;
		high_len <= 8'hC8;
		low_len <= 8'hC8;
		acc(5'h0D, 8'h01, 1'b1, 1'b0, q);
		run <= 1'b1;
		wait_match(n);
		@(negedge core_clk);
		`CHECK(timer_match_output, 1'b0);
		wait_match(n);
		`CHECK(n + 2, 9 + 1);
		acc(5'h0D, 8'h03, 1'b1, 1'b0, q);
		repeat (20) @(posedge core_clk);
		rd24(5'h01, v);
		`CHECK(v, 24'h000009);
		@(negedge core_clk);
		`CHECK(timer_match_output, 1'b1);
		acc(5'h0D, 8'h00, 1'b0, 1'b1, q);
		`CHECK(q, 8'h03);
		acc(5'h0E, 8'h01, 1'b1, 1'b1, q);
		`CHECK(q[0], 1'b1);
		$display("done period_match");
	endtask : t_match
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		apply_reset();
		t_reset_values();
		t_rw();
		t_sources();
		t_capture_ro();
		t_match();
		apply_reset();
		t_reset_values();
		wrap_up();
	end
endmodule : signal_measurement_timer_test
`default_nettype wire
